/* src/mptb_pkg.sv */
// package for the motor pwm time base: register map, field layout, types
// assumes a single 50 MHz clock domain and an axi4-lite register port
package mptb_pkg;
   // ==========================================================
   // register byte offsets
   localparam logic [4:0] MPTB_OFS_CTRL = 5'h00;
   localparam logic [4:0] MPTB_OFS_COUNT = 5'h04;
   localparam logic [4:0] MPTB_OFS_PERIOD = 5'h08;
   localparam logic [4:0] MPTB_OFS_STATUS = 5'h0C;
   localparam logic [4:0] MPTB_OFS_CLEAR = 5'h10;
   localparam logic [4:0] MPTB_OFS_ENABLE = 5'h14;
   // ==========================================================
   // control and count register fields
   localparam int MPTB_CTRL_ON_BIT = 15;
   localparam int MPTB_CTRL_OPS_LSB = 4;
   localparam int MPTB_CTRL_CKPS_LSB = 2;
   localparam int MPTB_CTRL_MOD_LSB = 0;
   localparam int MPTB_COUNT_DIR_BIT = 15;
   // status / enable bits
   localparam int MPTB_EV_BIT = 0;
   localparam int MPTB_EV_PERIOD_BIT = 1;
   localparam int MPTB_EV_ZERO_BIT = 2;
   localparam int MPTB_NUM_EV = 3;
   // ==========================================================
   // reset values and bus response codes
   localparam logic [14:0] MPTB_PERIOD_RST = 15'h0000;
   localparam logic [14:0] MPTB_COUNT_RST = 15'h0000;
   localparam logic [1:0] MPTB_RESP_OKAY = 2'h0;
   localparam logic [1:0] MPTB_RESP_SLVERR = 2'h2;
   // ==========================================================
   // counting modes
   typedef enum logic [1:0] {
      MPTB_FREE = 2'h0,
      MPTB_SINGLE = 2'h1,
      MPTB_UPDN = 2'h2,
      MPTB_DOUBLE = 2'h3
   } mptb_mode_e;
   // control fields travel together
   typedef struct packed {
      logic on;
      mptb_mode_e mode;
      logic [1:0] ckps;
      logic [3:0] ops;
   } mptb_ctrl_s;
   // bus slave state machine
   typedef enum logic [2:0] {
      MPTB_IDLE = 3'b001,
      MPTB_WRESP = 3'b010,
      MPTB_RRESP = 3'b100
   } mptb_bus_e;
endpackage : mptb_pkg

/* src/mptb_scaler.sv */
// programmable divider for the time base clock enable and match output
// assumes clear and tick come from the same clock domain
`timescale 1ns/10ps
module mptb_scaler
   import mptb_pkg::*;
#(
   parameter int WIDTH = 6
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // control
   input wire logic clr,
   input wire logic tick,
   input wire logic [WIDTH-1:0] limit,
   // result
   output logic pulse
);
   if (WIDTH < 1 || WIDTH > 16) begin : g_width_chk
      $error("mptb_scaler width out of range");
   end
   typedef struct packed {
      logic [WIDTH-1:0] cnt;
   } mptb_sc_s;
   mptb_sc_s st_q, st_d;
   // a pulse leaves on the tick that completes the ratio
   always_comb begin
      st_d = st_q;
      pulse = 1'b0;
      if (clr) begin
         st_d.cnt = '0;
      end else if (tick) begin
         if (st_q.cnt >= limit) begin
            st_d.cnt = '0;
            pulse = 1'b1;
         end else begin
            st_d.cnt = st_q.cnt + WIDTH'(1);
         end
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
endmodule // mptb_scaler

/* src/mptb_top.sv */
// motor pwm time base: 15-bit counter, prescaler, postscaler, four modes
// assumes an axi4-lite master on MCLK and an interrupt controller that
// latches the one-cycle event pulse
`timescale 1ns/10ps
// Notes on behaviour
// - 15-bit counter, prescaled input clock, postscaled match output.
// - count bit 15 reads direction, 1 when counting down, not writable.
// - on bit starts counter; clearing it holds the count.
// - at period match, next counter clock resets or reverses by mode.
// - zero period stops counting and suppresses all events.
// - a zero period is not updated; software disables first.
// - two-bit mode selects free, single-shot, up/down, double update.
// - events depend on mode and four-bit postscale select.
// - free mode counts up, resets after match, repeats while on.
// - mode 00 event at each match reset, postscaler divides.
// - single-shot counts up, resets after match, hardware clears on.
// - mode 01 one event at the match, postscaler ignored.
// - mode 10 turns down after match, event at zero, postscaled.
// - mode 11 events at zero and at match, postscaler ignored.
// - prescaler 1,4,16,64; cleared on count/control write or reset.
// - postscaler 1..16, cleared on count/control write or reset.
module mptb_top
   import mptb_pkg::*;
#(
   parameter int CNT_W = 15
) (
   // clock and reset
   input wire logic MCLK,
   input wire logic RSTN,
   // axi4-lite write address and data
   input wire logic [4:0] AWADDR,
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   // axi4-lite write response
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   // axi4-lite read
   input wire logic [4:0] ARADDR,
   input wire logic ARVALID,
   output logic ARREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY,
   // events to the rest of the pwm and interrupt controller
   output logic EVENT_FLAG,
   output logic PERIOD_MATCH,
   output logic COUNT_DOWN,
   output logic IRQ
);
   if (CNT_W != 15) begin : g_width_chk
      $error("mptb_top supports a 15-bit counter only");
   end

   // ==========================================================
   // reset release
   logic [1:0] rst_sync_q;
   logic rst_n;
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         rst_sync_q <= 2'b00;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // ==========================================================
   // all state of the block except the reset synchronizer and the two scaler counters
   typedef struct packed {
      mptb_bus_e bus;
      logic [4:0] awaddr;
      logic aw_got;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic w_got;
      logic [1:0] bresp;
      logic [31:0] rdata;
      logic [1:0] rresp;
      mptb_ctrl_s ctrl;
      logic [CNT_W-1:0] count;
      logic dir;
      logic [CNT_W-1:0] period;
      logic [CNT_W-1:0] period_buf;
      logic [MPTB_NUM_EV-1:0] status;
      logic [MPTB_NUM_EV-1:0] enable;
      logic event_flag;
      logic match_out;
      logic irq;
   } mptb_st_s;
   mptb_st_s st_q, st_d;

   // prescaler limit decode, shared by the divider instance
   function automatic logic [5:0] ckps_limit(input logic [1:0] sel);
      unique case (sel)
         2'd0: ckps_limit = 6'h00;
         2'd1: ckps_limit = 6'h03;
         2'd2: ckps_limit = 6'h0F;
         default: ckps_limit = 6'h3F;
      endcase
   endfunction

   // write data merged by byte strobes onto a 16-bit register
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0] be);
      merge16 = old;
      if (be[0]) merge16[7:0] = wd[7:0];
      if (be[1]) merge16[15:8] = wd[15:8];
   endfunction

   // ==========================================================
   // prescaler and postscaler
   logic wr_fire;
   logic wr_ctrl;
   logic wr_count;
   logic scaler_clr;
   logic cnt_tick;
   logic match_ev;
   logic post_pulse;
   assign scaler_clr = wr_ctrl | wr_count;

   mptb_scaler #(.WIDTH(6)) u_pre (
      .clk(MCLK),
      .rst_n(rst_n),
      .clr(scaler_clr),
      .tick(st_q.ctrl.on),
      .limit(ckps_limit(st_q.ctrl.ckps)),
      .pulse(cnt_tick)
   );

   mptb_scaler #(.WIDTH(4)) u_post (
      .clk(MCLK),
      .rst_n(rst_n),
      .clr(scaler_clr),
      .tick(match_ev),
      .limit(st_q.ctrl.ops),
      .pulse(post_pulse)
   );

   // ==========================================================
   // counter, bus slave and interrupt logic
   logic at_match;
   logic at_zero;
   logic run;
   logic raw_ev;
   logic ev_any;
   logic [MPTB_NUM_EV-1:0] ev_set;
   logic [15:0] tmp16;

   assign at_match = (st_q.count == st_q.period);
   assign at_zero = (st_q.count == '0) && st_q.ctrl.mode[1]; // up/down and double update modes only
   assign run = cnt_tick && (st_q.period != '0);
   assign wr_fire = (st_q.bus == MPTB_IDLE) && st_q.aw_got && st_q.w_got;
   assign wr_ctrl = wr_fire && (st_q.awaddr == MPTB_OFS_CTRL);
   assign wr_count = wr_fire && (st_q.awaddr == MPTB_OFS_COUNT);

   // match event feeding the postscaler: free and up/down turn points
   always_comb begin
      match_ev = 1'b0;
      if (run) begin
         unique case (st_q.ctrl.mode)
            MPTB_FREE: match_ev = at_match && !st_q.dir;
            MPTB_UPDN: match_ev = at_zero && st_q.dir;
            default: match_ev = 1'b0;
         endcase
      end
   end

   // raw event without postscaling for single and double update modes
   always_comb begin
      raw_ev = 1'b0;
      if (run) begin
         unique case (st_q.ctrl.mode)
            MPTB_SINGLE: raw_ev = at_match;
            MPTB_DOUBLE: raw_ev = at_match || (at_zero && st_q.dir);
            default: raw_ev = 1'b0;
         endcase
      end
   end
   assign ev_any = raw_ev | post_pulse;
   assign ev_set = {at_zero & run & st_q.dir, at_match & run, ev_any};

   always_comb begin
      st_d = st_q;
      tmp16 = 16'h0000;
      st_d.event_flag = ev_any;
      st_d.match_out = run && at_match;
      // counter step on each prescaled tick
      if (run) begin
         unique case (st_q.ctrl.mode)
            MPTB_FREE: begin
               st_d.dir = 1'b0;
               st_d.count = at_match ? '0 : st_q.count + 15'h0001;
            end
            MPTB_SINGLE: begin
               st_d.dir = 1'b0;
               if (at_match) begin
                  st_d.count = '0;
                  st_d.ctrl.on = 1'b0;
               end else begin
                  st_d.count = st_q.count + 15'h0001;
               end
            end
            default: begin
               // up/down: reverse at the period and at zero
               if (!st_q.dir && at_match) begin
                  st_d.dir = 1'b1;
                  st_d.count = st_q.count - 15'h0001;
               end else if (st_q.dir && at_zero) begin
                  st_d.dir = 1'b0;
                  st_d.count = st_q.count + 15'h0001;
               end else begin
                  st_d.count = st_q.dir ? st_q.count - 15'h0001
                                        : st_q.count + 15'h0001;
               end
            end
         endcase
      end
      // period buffer load at the documented instants; a zero live
      // period never reloads while running, since the counter stops
      if (!st_q.ctrl.on) begin
         st_d.period = st_q.period_buf;
      end else if (run && st_q.period != '0) begin
         if ((st_q.ctrl.mode inside {MPTB_FREE, MPTB_SINGLE}) && at_match) begin
            st_d.period = st_q.period_buf;
         end else if (!(st_q.ctrl.mode inside {MPTB_FREE, MPTB_SINGLE})
                      && at_zero) begin
            st_d.period = st_q.period_buf;
         end
      end
      // sticky status; hardware set wins over software clear
      st_d.status = st_q.status | ev_set;
      // bus channel capture
      if (AWVALID && AWREADY) begin
         st_d.awaddr = AWADDR;
         st_d.aw_got = 1'b1;
      end
      if (WVALID && WREADY) begin
         st_d.wdata = WDATA;
         st_d.wstrb = WSTRB;
         st_d.w_got = 1'b1;
      end
      unique case (st_q.bus)
         MPTB_IDLE: begin
            if (wr_fire) begin
               st_d.aw_got = 1'b0;
               st_d.w_got = 1'b0;
               st_d.bresp = MPTB_RESP_OKAY;
               st_d.bus = MPTB_WRESP;
               unique case (st_q.awaddr)
                  MPTB_OFS_CTRL: begin
                     tmp16 = merge16({st_q.ctrl.on, 7'h00, st_q.ctrl.ops,
                                      st_q.ctrl.ckps, st_q.ctrl.mode},
                                     st_q.wdata, st_q.wstrb);
                     st_d.ctrl.on = tmp16[MPTB_CTRL_ON_BIT];
                     st_d.ctrl.ops = tmp16[MPTB_CTRL_OPS_LSB +: 4];
                     st_d.ctrl.ckps = tmp16[MPTB_CTRL_CKPS_LSB +: 2];
                     st_d.ctrl.mode =
                        mptb_mode_e'(tmp16[MPTB_CTRL_MOD_LSB +: 2]);
                  end
                  MPTB_OFS_COUNT: begin
                     tmp16 = merge16({1'b0, st_q.count}, st_q.wdata,
                                     st_q.wstrb);
                     st_d.count = tmp16[CNT_W-1:0]; // direction ignored
                  end
                  MPTB_OFS_PERIOD: begin
                     tmp16 = merge16({1'b0, st_q.period_buf}, st_q.wdata,
                                     st_q.wstrb);
                     st_d.period_buf = tmp16[CNT_W-1:0];
                  end
                  MPTB_OFS_CLEAR: begin
                     st_d.status = (st_q.status
                        & ~st_q.wdata[MPTB_NUM_EV-1:0]) | ev_set;
                  end
                  MPTB_OFS_ENABLE: begin
                     st_d.enable = st_q.wdata[MPTB_NUM_EV-1:0];
                  end
                  MPTB_OFS_STATUS: ;
                  default: st_d.bresp = MPTB_RESP_SLVERR;
               endcase
            end else if (ARVALID) begin
               st_d.bus = MPTB_RRESP;
               st_d.rresp = MPTB_RESP_OKAY;
               unique case (ARADDR)
                  MPTB_OFS_CTRL: st_d.rdata = {16'h0000, st_q.ctrl.on,
                     7'h00, st_q.ctrl.ops, st_q.ctrl.ckps, st_q.ctrl.mode};
                  MPTB_OFS_COUNT: st_d.rdata =
                     {16'h0000, st_q.dir, st_q.count};
                  MPTB_OFS_PERIOD: st_d.rdata = {17'h0_0000, st_q.period_buf};
                  MPTB_OFS_STATUS: st_d.rdata = {29'h0, st_q.status};
                  MPTB_OFS_ENABLE: st_d.rdata = {29'h0, st_q.enable};
                  MPTB_OFS_CLEAR: st_d.rdata = 32'h0000_0000;
                  default: begin
                     st_d.rdata = 32'h0000_0000;
                     st_d.rresp = MPTB_RESP_SLVERR;
                  end
               endcase
            end
         end
         MPTB_WRESP: if (BREADY) st_d.bus = MPTB_IDLE;
         MPTB_RRESP: if (RREADY) st_d.bus = MPTB_IDLE;
         default: st_d.bus = MPTB_IDLE;
      endcase
      st_d.irq = |(st_d.status & st_d.enable);
   end

   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= '0;
         st_q.bus <= MPTB_IDLE;
         st_q.count <= MPTB_COUNT_RST;
         st_q.period <= MPTB_PERIOD_RST;
         st_q.period_buf <= MPTB_PERIOD_RST;
      end else begin
         st_q <= st_d;
      end
   end

   // ==========================================================
   // outputs, all from flip-flops
   assign AWREADY = (st_q.bus == MPTB_IDLE) && !st_q.aw_got;
   assign WREADY = (st_q.bus == MPTB_IDLE) && !st_q.w_got;
   assign ARREADY = (st_q.bus == MPTB_IDLE) && !(st_q.aw_got && st_q.w_got);
   assign BVALID = st_q.bus[1];
   assign BRESP = st_q.bresp;
   assign RVALID = st_q.bus[2];
   assign RDATA = st_q.rdata;
   assign RRESP = st_q.rresp;
   assign EVENT_FLAG = st_q.event_flag;
   assign PERIOD_MATCH = st_q.match_out;
   assign COUNT_DOWN = st_q.dir;
   assign IRQ = st_q.irq;
endmodule // mptb_top

/* tb/mptb_checker.sv */
// concurrent checks on the time base ports: bus answers, event pulses
// assumes one clock domain and a bind onto every mptb_top instance
`timescale 1ns/10ps
module mptb_checker (
   // clock and reset
   input wire logic MCLK,
   input wire logic RSTN,
   // register bus
   input wire logic AWVALID,
   input wire logic AWREADY,
   input wire logic WVALID,
   input wire logic WREADY,
   input wire logic [1:0] BRESP,
   input wire logic BVALID,
   input wire logic BREADY,
   input wire logic ARVALID,
   input wire logic ARREADY,
   input wire logic [31:0] RDATA,
   input wire logic RVALID,
   input wire logic RREADY,
   // time base events
   input wire logic EVENT_FLAG,
   input wire logic PERIOD_MATCH,
   input wire logic COUNT_DOWN,
   input wire logic IRQ
);
   // any half of a write taken this cycle
   logic wtk;
   assign wtk = (WVALID && WREADY) || (AWVALID && AWREADY);
   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (!RSTN);
   // ==========================================================
   // bus answers must stand until the master takes them
   a_bresp_stands: assert property (
      BVALID && !BREADY |=> BVALID && $stable(BRESP))
      else $error("write response dropped before taken");
   a_rdata_stands: assert property (
      RVALID && !RREADY |=> RVALID && $stable(RDATA))
      else $error("read data dropped before taken");
   a_write_answer: assert property (
      AWVALID && AWREADY && WVALID && WREADY |-> ##[1:2] BVALID)
      else $error("write response late");
   a_read_answer: assert property (
      ARVALID && ARREADY |-> ##[1:2] RVALID)
      else $error("read response late");
   // a pending response refuses new write halves
   a_busy_refuse: assert property (
      BVALID |-> !AWREADY && !WREADY)
      else $error("write taken while response pending");
   // ==========================================================
   // time base events
   a_event_single: assert property (
      EVENT_FLAG |=> !EVENT_FLAG)
      else $error("event flag longer than one cycle");
   a_match_single: assert property (
      PERIOD_MATCH |=> !PERIOD_MATCH)
      else $error("period match longer than one cycle");
   // turning down is only legal right at a period match
   a_turn_at_match: assert property (
      $rose(COUNT_DOWN) |->
         PERIOD_MATCH || $past(PERIOD_MATCH) || $past(PERIOD_MATCH, 2))
      else $error("direction turned without a match");
   // sticky status only drops through a register write
   a_irq_drop_cause: assert property (
      $fell(IRQ) |-> $past(wtk) || $past(wtk, 2) || $past(wtk, 3)
         || $past(wtk, 4))
      else $error("interrupt dropped without a write");
endmodule // mptb_checker
bind mptb_top mptb_checker u_chk (.*);

/* tb/tb_top.sv */
// self-checking bench for mptb_top: axi4-lite tasks and mode tests
// assumes the checker binds itself and the dut uses default parameters
`timescale 1ns/10ps
module tb_top;
   import mptb_pkg::*;
   logic MCLK = 1'b0;
   logic RSTN = 1'b0;
   logic [4:0] AWADDR = 5'h00;
   logic [4:0] ARADDR = 5'h00;
   logic [31:0] WDATA = 32'h0000_0000;
   logic [3:0] WSTRB = 4'h0;
   logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0;
   logic ARVALID = 1'b0, RREADY = 1'b0;
   logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
   logic EVENT_FLAG, PERIOD_MATCH, COUNT_DOWN, IRQ;
   logic [1:0] BRESP, RRESP;
   logic [31:0] RDATA;
   int failures = 0;
   int compares = 0;
   int cyc = 0, evn = 0, last = 0, gp = 0;
   // free-running settings and the event spacing each must give
   logic [31:0] tc [6] = '{32'h0000_8000, 32'h0000_8010, 32'h0000_80F0,
      32'h0000_8004, 32'h0000_8008, 32'h0000_800C};
   int te [6] = '{4, 8, 64, 16, 64, 256};
   mptb_top u_dut (.*);
   always #10 MCLK = ~MCLK;
   // event count and spacing; read one cycle late, never racing
   always @(posedge MCLK) begin
      cyc <= cyc + 1;
      if (EVENT_FLAG === 1'b1) begin
         evn <= evn + 1;
         gp <= cyc - last;
         last <= cyc;
      end
   end
   // ==========================================================
   // reporting
   task automatic conclude();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e) begin
         failures++;
         $display("Error at %0t: saw %h expected %h", $time, s, e);
      end
   endtask
   task automatic tmo();
      failures++;
      $display("Error at %0t: wait ran out", $time);
      conclude();
   endtask
   // ==========================================================
   // axi4-lite master
   task automatic wr(input logic [4:0] a, input logic [31:0] d,
      input logic [1:0] er = MPTB_RESP_OKAY);
      int n;
      n = 0;
      @(posedge MCLK);
      AWADDR <= a;
      WDATA <= d;
      WSTRB <= 4'hF;
      AWVALID <= 1'b1;
      WVALID <= 1'b1;
      BREADY <= 1'b1;
      do begin
         @(posedge MCLK);
         n++;
         if (AWREADY === 1'b1) AWVALID <= 1'b0;
         if (WREADY === 1'b1) WVALID <= 1'b0;
      end while (BVALID !== 1'b1 && n < 50);
      if (n >= 50) tmo();
      chk(32'(BRESP), 32'(er));
      BREADY <= 1'b0;
   endtask
   task automatic rd(input logic [4:0] a, output logic [31:0] d,
      output logic [1:0] r);
      int n;
      n = 0;
      @(posedge MCLK);
      ARADDR <= a;
      ARVALID <= 1'b1;
      RREADY <= 1'b1;
      do begin
         @(posedge MCLK);
         n++;
         if (ARREADY === 1'b1) ARVALID <= 1'b0;
      end while (RVALID !== 1'b1 && n < 50);
      if (n >= 50) tmo();
      d = RDATA;
      r = RRESP;
      RREADY <= 1'b0;
   endtask
   task automatic rc(input logic [4:0] a, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0] r;
      rd(a, d, r);
      chk(d, e);
   endtask
   // ==========================================================
   // time base helpers
   task automatic wev(input int k);
      int t0, n;
      t0 = evn;
      n = 0;
      while (evn < t0 + k && n < 4000) begin
         @(posedge MCLK);
         n++;
      end
      if (n >= 4000) tmo();
   endtask
   // stop, zero the count (clears both scalers), then start
   task automatic go(input logic [31:0] c);
      wr(MPTB_OFS_CTRL, 32'h0000_0000);
      wr(MPTB_OFS_COUNT, 32'h0000_0000);
      wr(MPTB_OFS_CTRL, c);
   endtask
   // ==========================================================
   // main sequence
   initial begin
      logic [31:0] d;
      logic [1:0] r;
      int g0, g1, n;
      repeat (5) @(posedge MCLK);
      RSTN <= 1'b1;
      repeat (4) @(posedge MCLK);
      rc(MPTB_OFS_CTRL, 32'h0000_0000);
      rc(MPTB_OFS_PERIOD, 32'h0000_0000);
      rc(MPTB_OFS_STATUS, 32'h0000_0000);
      rd(5'h18, d, r);
      chk(32'(r), 32'(MPTB_RESP_SLVERR));
      wr(5'h18, 32'h0000_1234, MPTB_RESP_SLVERR);
      wr(MPTB_OFS_COUNT, 32'h0000_8005);
      rc(MPTB_OFS_COUNT, 32'h0000_0005);
      wr(MPTB_OFS_CTRL, 32'h0000_00F4);
      rc(MPTB_OFS_COUNT, 32'h0000_0005);
      wr(MPTB_OFS_PERIOD, 32'h0000_0003);
      rc(MPTB_OFS_PERIOD, 32'h0000_0003);
      rc(MPTB_OFS_CLEAR, 32'h0000_0000);
      $display("test registers done");
      for (int i = 0; i < 6; i++) begin
         go(tc[i]);
         wev(2);
         chk(32'(gp), 32'(te[i]));
      end
      $display("test free running done");
      go(32'h0000_8002);
      wev(2);
      g0 = gp;
      go(32'h0000_8012);
      wev(2);
      chk(32'(gp), 32'(2 * g0));
      go(32'h0000_80F3);
      wev(2);
      g1 = gp;
      wev(1);
      chk(32'(g1 + gp), 32'(g0));
      go(32'h0000_800E);
      n = 0;
      // a direction left set by the last run must clear before the turn
      while (COUNT_DOWN !== 1'b0 && n < 2000) begin
         @(posedge MCLK);
         n++;
      end
      while (COUNT_DOWN !== 1'b1 && n < 2000) begin
         @(posedge MCLK);
         n++;
      end
      if (n >= 2000) tmo();
      rd(MPTB_OFS_COUNT, d, r);
      chk(32'(d[15]), 32'h0000_0001);
      $display("test up down done");
      wr(MPTB_OFS_CTRL, 32'h0000_0000);
      wr(MPTB_OFS_CLEAR, 32'h0000_0007);
      go(32'h0000_8031);
      wev(1);
      g0 = evn;
      repeat (40) @(posedge MCLK);
      chk(32'(evn), 32'(g0));
      rc(MPTB_OFS_CTRL, 32'h0000_0031);
      rc(MPTB_OFS_COUNT, 32'h0000_0000);
      rc(MPTB_OFS_STATUS, 32'h0000_0003);
      $display("test single shot done");
      wr(MPTB_OFS_ENABLE, 32'h0000_0001);
      repeat (3) @(posedge MCLK);
      chk(32'(IRQ), 32'h0000_0001);
      wr(MPTB_OFS_ENABLE, 32'h0000_0000);
      repeat (3) @(posedge MCLK);
      chk(32'(IRQ), 32'h0000_0000);
      wr(MPTB_OFS_ENABLE, 32'h0000_0002);
      repeat (3) @(posedge MCLK);
      chk(32'(IRQ), 32'h0000_0001);
      wr(MPTB_OFS_CLEAR, 32'h0000_0003);
      repeat (3) @(posedge MCLK);
      chk(32'(IRQ), 32'h0000_0000);
      rc(MPTB_OFS_STATUS, 32'h0000_0000);
      $display("test interrupt done");
      go(32'h0000_800C);
      repeat (100) @(posedge MCLK);
      wr(MPTB_OFS_CTRL, 32'h0000_000C);
      rd(MPTB_OFS_COUNT, d, r);
      chk(32'(d != 32'h0000_0000), 32'h0000_0001);
      repeat (200) @(posedge MCLK);
      rc(MPTB_OFS_COUNT, d);
      $display("test hold done");
      wr(MPTB_OFS_PERIOD, 32'h0000_0000);
      go(32'h0000_8000);
      g0 = evn;
      repeat (60) @(posedge MCLK);
      chk(32'(evn), 32'(g0));
      rc(MPTB_OFS_COUNT, 32'h0000_0000);
      wr(MPTB_OFS_PERIOD, 32'h0000_0005);
      repeat (60) @(posedge MCLK);
      chk(32'(evn), 32'(g0));
      go(32'h0000_8000);
      wev(2);
      chk(32'(gp), 32'h0000_0006);
      $display("test zero period done");
      conclude();
   end
endmodule // tb_top
